// ---- logic/ldc_pkg.sv ----
// shared constants and carriers for the duty/partial/rmw command decoder
package ldc_pkg;
  localparam logic [7:0] LDC_CMD_DUTY = 8'h6D;
  localparam logic [7:0] LDC_CMD_PART_OFF = 8'h96;
  localparam logic [7:0] LDC_CMD_PART_ON = 8'h97;
  localparam logic [7:0] LDC_CMD_PART_AREA = 8'h32;
  localparam logic [7:0] LDC_CMD_RMW_ENTER = 8'hE0;
  localparam logic [7:0] LDC_CMD_RMW_END = 8'hEE;
  localparam logic [7:0] LDC_CMD_OSC_OFF = 8'hAA;
  localparam logic [7:0] LDC_CMD_OSC_ON = 8'hAB;
  localparam int LDC_FLAG_BIT = 0;
  localparam int LDC_FIELD_W = 6;
  localparam logic [5:0] LDC_DUTY_RST = 6'h20;
  localparam logic [5:0] LDC_BLOCK_RST = 6'h00;
  localparam logic LDC_PART_RST = 1'b0;
  localparam logic LDC_OSC_RST = 1'b0;
  localparam logic [9:0] LDC_ROW_TOTAL = 10'h084;
  localparam logic [8:0] LDC_LINE_LIMIT = 9'h084;

  typedef enum logic [2:0] {
    LDC_IDLE = 3'b000,
    LDC_DUTY_P1 = 3'b001,
    LDC_DUTY_P2 = 3'b011,
    LDC_PART_P1 = 3'b010,
    LDC_PART_P2 = 3'b110
  } ldc_phase_type;

  typedef struct packed {
    logic wr;
    logic cds;
    logic [7:0] data;
  } ldc_host_wr_type;

  typedef struct packed {
    logic [5:0] duty_code;
    logic [5:0] start_block;
    logic [8:0] rows_driven;
    logic [7:0] row_first;
    logic [7:0] row_last;
  } ldc_drive_type;

  typedef struct packed {
    logic on;
    logic [7:0] start_line;
    logic [7:0] line_count;
    logic invalid;
  } ldc_partial_type;
endpackage : ldc_pkg

// ---- logic/ldc_pin_sync.sv ----
// three-stage pin synchroniser, change accepted when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module ldc_pin_sync (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_pin,
  output logic o_level
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } ldc_sync_state_type;

  ldc_sync_state_type st_r;
  ldc_sync_state_type st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = i_pin;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    if (st_r.s2 == st_r.s3) begin
      st_nxt.lvl = st_r.s3;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_level = st_r.lvl;
endmodule : ldc_pin_sync
`default_nettype wire

// ---- logic/ldc_cmd_decoder.sv ----
// command decoder for duty, partial display, read-modify-write and oscillator control
// Notes on behaviour
// - six-bit duty code n drives 4(n+1) rows, 1/4 up to 1/132
// - reset sets the duty code to the 1/132 setting
// - start block k begins the driven area at row 4k, 33 blocks
// - reset clears the start block to zero
// - driven rows run from the start block for duty rows, wrapping past 131
// - command 0x96 or 0x97 turns partial display off or on by bit zero
// - partial area command takes first line then line count, in that order
// - partial area command never alters the duty setting
// - first line plus count beyond 132 is flagged invalid
// - 0xE0 enters rmw, saves column; reads hold, writes advance column
// - 0xEE leaves rmw and restores the saved column
// - 0xAA stops, 0xAB starts oscillator only with both select pins high
`timescale 1ns/1ps
`default_nettype none
module ldc_cmd_decoder #(
  parameter int COL_W = 8,
  parameter logic [7:0] COL_LAST = 8'h83
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire ldc_pkg::ldc_host_wr_type i_host,
  input wire logic i_data_rd,
  input wire logic i_col_set,
  input wire logic [7:0] i_col_value,
  input wire logic i_master_select,
  input wire logic i_oscillator_source_select,
  output ldc_pkg::ldc_drive_type o_drive,
  output ldc_pkg::ldc_partial_type o_partial,
  output logic o_rmw_active,
  output logic [7:0] o_col_addr,
  output logic o_data_wr,
  output logic o_osc_on
);
  import ldc_pkg::*;

  typedef struct packed {
    ldc_phase_type phase;
    logic [5:0] duty_code;
    logic [5:0] start_block;
    logic part_on;
    logic [7:0] part_start;
    logic [7:0] part_count;
    logic rmw;
    logic [7:0] col;
    logic [7:0] col_save;
    logic data_wr;
    logic osc_on;
  } ldc_state_type;

  ldc_state_type st_r;
  ldc_state_type st_nxt;
  logic ms_lvl;
  logic cls_lvl;
  logic cmd_wr;
  logic par_wr;
  logic osc_gate;
  logic [7:0] col_inc;
  logic [9:0] row_end;
  logic [9:0] row_first_w;
  logic [9:0] row_wrap;

  ldc_pin_sync u_ms_sync (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_pin(i_master_select),
    .o_level(ms_lvl)
  );

  ldc_pin_sync u_cls_sync (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_pin(i_oscillator_source_select),
    .o_level(cls_lvl)
  );

  assign cmd_wr = i_host.wr && !i_host.cds;
  assign par_wr = i_host.wr && i_host.cds;
  assign osc_gate = ms_lvl && cls_lvl;
  assign col_inc = (st_r.col == COL_LAST) ? 8'h00 : 8'(st_r.col + 8'h01);

  always_comb begin
    st_nxt = st_r;
    st_nxt.data_wr = 1'b0;
    if (cmd_wr) begin
      st_nxt.phase = LDC_IDLE;
      case (i_host.data)
        LDC_CMD_DUTY: begin
          st_nxt.phase = LDC_DUTY_P1;
        end
        LDC_CMD_PART_AREA: begin
          st_nxt.phase = LDC_PART_P1;
        end
        LDC_CMD_PART_OFF, LDC_CMD_PART_ON: begin
          st_nxt.part_on = i_host.data[LDC_FLAG_BIT];
        end
        LDC_CMD_RMW_ENTER: begin
          if (!st_r.rmw) begin
            st_nxt.col_save = st_r.col;
          end
          st_nxt.rmw = 1'b1;
        end
        LDC_CMD_RMW_END: begin
          if (st_r.rmw) begin
            st_nxt.col = st_r.col_save;
          end
          st_nxt.rmw = 1'b0;
        end
        LDC_CMD_OSC_OFF, LDC_CMD_OSC_ON: begin
          if (osc_gate) begin
            st_nxt.osc_on = i_host.data[LDC_FLAG_BIT];
          end
        end
        default: begin
        end
      endcase
    end else if (par_wr) begin
      case (st_r.phase)
        LDC_DUTY_P1: begin
          st_nxt.duty_code = i_host.data[LDC_FIELD_W-1:0];
          st_nxt.phase = LDC_DUTY_P2;
        end
        LDC_DUTY_P2: begin
          st_nxt.start_block = i_host.data[LDC_FIELD_W-1:0];
          st_nxt.phase = LDC_IDLE;
        end
        LDC_PART_P1: begin
          st_nxt.part_start = i_host.data;
          st_nxt.phase = LDC_PART_P2;
        end
        LDC_PART_P2: begin
          st_nxt.part_count = i_host.data;
          st_nxt.phase = LDC_IDLE;
        end
        default: begin
          st_nxt.data_wr = 1'b1;
          st_nxt.col = col_inc;
        end
      endcase
    end
    if (i_data_rd && !st_r.rmw && !par_wr) begin
      st_nxt.col = col_inc;
    end
    if (i_col_set && !cmd_wr) begin
      st_nxt.col = i_col_value;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      st_r <= '0;
      st_r.phase <= LDC_IDLE;
      st_r.duty_code <= LDC_DUTY_RST;
      st_r.start_block <= LDC_BLOCK_RST;
      st_r.part_on <= LDC_PART_RST;
      st_r.osc_on <= LDC_OSC_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // driven row window with wrap past the last row
  always_comb begin
    row_first_w = {2'b00, st_r.start_block, 2'b00};
    row_end = 10'(row_first_w + {st_r.duty_code, 2'b11});
    row_wrap = row_end;
    if (row_end >= 10'(LDC_ROW_TOTAL + LDC_ROW_TOTAL)) begin
      row_wrap = 10'(row_end - LDC_ROW_TOTAL - LDC_ROW_TOTAL);
    end else if (row_end >= LDC_ROW_TOTAL) begin
      row_wrap = 10'(row_end - LDC_ROW_TOTAL);
    end
  end

  assign o_drive.duty_code = st_r.duty_code;
  assign o_drive.start_block = st_r.start_block;
  assign o_drive.rows_driven = {1'b0, st_r.duty_code, 2'b00} + 9'h004;
  assign o_drive.row_first = row_first_w[7:0];
  assign o_drive.row_last = row_wrap[7:0];
  assign o_partial.on = st_r.part_on;
  assign o_partial.start_line = st_r.part_start;
  assign o_partial.line_count = st_r.part_count;
  assign o_partial.invalid = (9'(st_r.part_start) + 9'(st_r.part_count)) > LDC_LINE_LIMIT;
  assign o_rmw_active = st_r.rmw;
  assign o_col_addr = st_r.col;
  assign o_data_wr = st_r.data_wr;
  assign o_osc_on = st_r.osc_on;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_srst);

  a_duty_reset: assert property (@(posedge i_clk) disable iff (1'b0) i_srst |=>
    (st_r.duty_code == 6'h20 && st_r.start_block == 6'h00)) else $error("duty reset values wrong");
  a_duty_pair: assert property (cmd_wr && i_host.data == 8'h6D ##1 par_wr ##1 par_wr |=>
    (st_r.duty_code == $past(i_host.data[5:0], 2) && st_r.start_block == $past(i_host.data[5:0])))
    else $error("duty pair not captured");
  a_rows_count: assert property (o_drive.rows_driven == 9'(4 * (int'(st_r.duty_code) + 1)))
    else $error("rows driven mismatch");
  a_partial_flag: assert property (cmd_wr && i_host.data[7:1] == 7'h4B |=>
    o_partial.on == $past(i_host.data[0])) else $error("partial flag wrong");
  a_partial_keep: assert property (st_r.phase inside {LDC_PART_P1, LDC_PART_P2} && par_wr |=>
    $stable(st_r.duty_code)) else $error("partial area changed duty");
  a_partial_order: assert property (cmd_wr && i_host.data == 8'h32 ##1 par_wr ##1 par_wr |=>
    o_partial.start_line == $past(i_host.data, 2) && o_partial.line_count == $past(i_host.data))
    else $error("partial parameters out of order");
  a_rmw_hold: assert property (st_r.rmw && i_data_rd && !i_host.wr && !i_col_set |=>
    $stable(o_col_addr)) else $error("rmw read moved column");
  a_rmw_restore: assert property (cmd_wr && i_host.data == 8'hE0 && !st_r.rmw ##1 (st_r.rmw && !cmd_wr)[*3]
    ##1 cmd_wr && i_host.data == 8'hEE |=> o_col_addr == $past(o_col_addr, 5))
    else $error("rmw end did not restore column");
  a_osc_gate: assert property (cmd_wr && i_host.data[7:1] == 7'h55 && !osc_gate |=> $stable(o_osc_on))
    else $error("oscillator changed without pin enable");
  a_cmd_abort: assert property (st_r.phase != LDC_IDLE && cmd_wr && i_host.data != 8'h6D
    && i_host.data != 8'h32 |=> st_r.phase == LDC_IDLE) else $error("pending parameters kept");
  a_invalid_flag: assert property (st_r.phase == LDC_PART_P2 && par_wr |=>
    o_partial.invalid == ((9'($past(st_r.part_start)) + 9'($past(i_host.data))) > 9'h084))
    else $error("partial invalid flag wrong");

  c_duty_set: cover property (cmd_wr && i_host.data == 8'h6D ##1 par_wr ##1 par_wr);
  c_rmw_cycle: cover property (cmd_wr && i_host.data == 8'hE0 ##[1:20] cmd_wr && i_host.data == 8'hEE);
  c_osc_on: cover property (osc_gate && cmd_wr && i_host.data == 8'hAB);
  c_row_wrap: cover property (row_end >= LDC_ROW_TOTAL);
endmodule : ldc_cmd_decoder
`default_nettype wire

// ---- tb/ldc_host_model.sv ----
// host model writing command and parameter bytes
`timescale 1ns/1ps
`default_nettype none
module ldc_host_model (
  input wire logic i_clk,
  output var ldc_pkg::ldc_host_wr_type o_host
);
  import ldc_pkg::*;
  initial o_host = '{wr: 1'b0, cds: 1'b1, data: 8'h00};
  // one byte per cycle, chained sends keep parameters back to back
  task automatic send(input logic cds, input logic [7:0] data);
    @(posedge i_clk);
    o_host <= '{wr: 1'b1, cds: cds, data: data};
  endtask : send
  // released byte shows the inverse of the last one
  task automatic idle();
    @(posedge i_clk);
    o_host <= '{wr: 1'b0, cds: ~o_host.cds, data: ~o_host.data};
  endtask : idle
endmodule : ldc_host_model
`default_nettype wire

// ---- tb/tb.sv ----
// self-checking bench for the command decoder
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ldc_pkg::*;
  logic i_clk = 0, i_srst = 1, rd = 0, cset = 0, ms = 0, oss = 0;
  logic [7:0] cval = 8'h00, col, e_sl = 8'h00, e_lc = 8'h00, e_col = 8'h00;
  logic [5:0] e_duty = LDC_DUTY_RST, e_blk = LDC_BLOCK_RST;
  logic e_on = 0, e_rmw = 0, e_osc = 0, e_dwr = 0, rmw, dwr, osc;
  ldc_host_wr_type host;
  ldc_drive_type drv;
  ldc_partial_type par;
  int mismatches = 0, checks_done = 0, seed = 37;
  logic [65:0] q[$];
  event look;
  initial forever #12.5 i_clk = ~i_clk;
  ldc_host_model ldc_host_model_inst (.i_clk(i_clk), .o_host(host));
  ldc_cmd_decoder ldc_cmd_decoder_inst (.i_clk(i_clk), .i_srst(i_srst), .i_host(host), .i_data_rd(rd),
    .i_col_set(cset), .i_col_value(cval), .i_master_select(ms), .i_oscillator_source_select(oss),
    .o_drive(drv), .o_partial(par), .o_rmw_active(rmw), .o_col_addr(col), .o_data_wr(dwr), .o_osc_on(osc));
  function automatic logic [65:0] expv();
    logic [9:0] last;
    last = (10'(e_blk) * 10'd4 + 10'(e_duty) * 10'd4 + 10'd3) % LDC_ROW_TOTAL;
    return {e_duty, e_blk, 9'(e_duty) * 9'h004 + 9'h004, 8'(e_blk) * 8'h04, last[7:0], e_on, e_sl, e_lc,
      (9'(e_sl) + 9'(e_lc)) > LDC_LINE_LIMIT, e_rmw, e_col, e_osc, e_dwr};
  endfunction : expv
  task automatic cmp(input string name, input logic [65:0] seen, input logic [65:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : cmp
  task automatic note();
    q.push_back(expv());
    -> look;
  endtask : note
  task automatic wr(input logic cds, input logic [7:0] v);
    ldc_host_model_inst.send(cds, v);
  endtask : wr
  task automatic done();
    ldc_host_model_inst.idle();
    note();
  endtask : done
  task automatic pulse(input logic r, input logic s, input logic [7:0] v);
    @(posedge i_clk);
    rd <= r;
    cset <= s;
    cval <= v;
    @(posedge i_clk);
    rd <= 1'b0;
    cset <= 1'b0;
    cval <= ~v;
    note();
  endtask : pulse
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish
  initial forever begin
    @(look);
    @(negedge i_clk);
    cmp("outputs", {drv, par, rmw, col, osc, dwr}, q.pop_front());
  end
  initial begin
    #(25 * 4000);
    mismatches++;
    tally_and_finish();
  end
  initial begin
    logic [7:0] sls[3];
    logic [7:0] lcs[3];
    sls = '{8'd100, 8'd0, 8'd17};
    lcs = '{8'd40, 8'd132, 8'd60};
    repeat (10) @(posedge i_clk);
    i_srst <= 1'b0;
    done();
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      e_duty = (i == 0) ? 6'd32 : 6'($unsigned($random(seed)) % 33);
      e_blk = (i < 2) ? 6'(32 - i * 6) : 6'($unsigned($random(seed)) % 33);
      wr(0, LDC_CMD_DUTY);
      wr(1, {2'b00, e_duty});
      wr(1, {2'b11, e_blk});
      done();
    end
    $display("test duty done");
    // abandoned start block, trailing byte becomes a data write
    wr(0, LDC_CMD_DUTY);
    wr(1, 8'h05);
    wr(0, LDC_CMD_PART_ON);
    wr(1, 8'h3C);
    e_duty = 6'd5;
    e_on = 1'b1;
    e_col = 8'h01;
    e_dwr = 1'b1;
    done();
    e_dwr = 1'b0;
    for (int i = 0; i < 3; i++) begin
      wr(0, LDC_CMD_PART_AREA);
      wr(1, sls[i]);
      wr(1, lcs[i]);
      e_sl = sls[i];
      e_lc = lcs[i];
      done();
    end
    wr(0, LDC_CMD_PART_OFF);
    e_on = 1'b0;
    done();
    $display("test partial done");
    e_col = 8'd130;
    pulse(0, 1, 8'd130);
    wr(0, LDC_CMD_RMW_ENTER);
    e_rmw = 1'b1;
    done();
    wr(1, 8'($random(seed)));
    wr(1, 8'($random(seed)));
    e_col = 8'd0;
    e_dwr = 1'b1;
    done();
    e_dwr = 1'b0;
    pulse(1, 0, 8'h00);
    wr(0, LDC_CMD_RMW_END);
    e_rmw = 1'b0;
    e_col = 8'd130;
    done();
    e_col = 8'd131;
    pulse(1, 0, 8'h00);
    // three writes inside the mode, the first wrapping to 0, then end restores 131
    wr(0, LDC_CMD_RMW_ENTER);
    repeat (3) wr(1, 8'($random(seed)));
    wr(0, LDC_CMD_RMW_END);
    done();
    $display("test rmw done");
    for (int i = 0; i < 8; i++) begin
      @(posedge i_clk);
      ms <= i[0];
      oss <= i[1];
      repeat (6) @(posedge i_clk);
      wr(0, i[2] ? LDC_CMD_OSC_OFF : LDC_CMD_OSC_ON);
      if (i[0] & i[1]) e_osc = ~i[2];
      done();
    end
    $display("test osc done");
    @(posedge i_clk);
    i_srst <= 1'b1;
    repeat (4) @(posedge i_clk);
    i_srst <= 1'b0;
    {e_duty, e_blk, e_col, e_sl, e_lc, e_osc} = {LDC_DUTY_RST, LDC_BLOCK_RST, 25'h0};
    done();
    $display("test rereset done");
    repeat (2) @(posedge i_clk);
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
